// ### rtl/ctpwm_cfg.svh
// Constants for the cascaded 16-bit timer and PWM unit.
`ifndef CTPWM_CFG_SVH
`define CTPWM_CFG_SVH
// Width of the cascaded counter and of each half.
`define CTPWM_CNT_W 16
`define CTPWM_HALF_W 8
// Prescale tap exponents of the high clock.
`define CTPWM_TAP_HI11 11
`define CTPWM_TAP_HI7 7
`define CTPWM_TAP_HI5 5
`define CTPWM_TAP_HI3 3
`define CTPWM_TAP_HI1 1
// Prescale tap exponent of the low clock.
`define CTPWM_TAP_LO3 3
// Divider width needed for the deepest tap.
`define CTPWM_DIV_W 11
// Reset values.
`define CTPWM_CNT_RST 16'h0000
`define CTPWM_DUTY_RST 16'hffff
`endif

// ### rtl/ctpwm_pkg.sv
// Types for the cascaded 16-bit timer and PWM unit.
package ctpwm_pkg;
   // Operating mode of the cascaded pair.
   typedef enum logic [1:0] {
      CTPWM_MODE_TIMER,
      CTPWM_MODE_EVENT,
      CTPWM_MODE_PWM,
      CTPWM_MODE_RSVD
   } ctpwm_mode_t;
   // Source clock selection.
   typedef enum logic [2:0] {
      CTPWM_SRC_TAP1,
      CTPWM_SRC_HI7,
      CTPWM_SRC_HI5,
      CTPWM_SRC_HI3,
      CTPWM_SRC_LOW,
      CTPWM_SRC_HI1,
      CTPWM_SRC_HI,
      CTPWM_SRC_EXT
   } ctpwm_src_t;
endpackage : ctpwm_pkg

// ### rtl/ctpwm_tick.sv
// Tick generator: prescaler taps and synchronised external edge detector.
`timescale 1ns/1ps
`include "ctpwm_cfg.svh"
module ctpwm_tick
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic high_clock_en_i,
   input wire logic low_clock_en_i,
   input wire logic prescale_select_bit_i,
   input wire logic slow_mode_i,
   input wire logic pwm_mode_i,
   input wire ctpwm_pkg::ctpwm_src_t src_i,
   input wire logic event_input_pin_i,
   output logic tick_o
);
   import ctpwm_pkg::*;

   // ----------------------------------------------------------------
   // Prescalers
   // ----------------------------------------------------------------
   logic [`CTPWM_DIV_W-1:0] hdiv_r;
   logic [`CTPWM_TAP_LO3-1:0] ldiv_r;
   logic [`CTPWM_DIV_W-1:0] hdiv_nxt;
   logic [`CTPWM_TAP_LO3-1:0] ldiv_nxt;

   assign hdiv_nxt = hdiv_r + `CTPWM_DIV_W'(1);
   assign ldiv_nxt = ldiv_r + `CTPWM_TAP_LO3'(1);

   // Free running dividers advance only on enables of their source clocks.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         hdiv_r <= '0;
         ldiv_r <= '0;
      end
      else
      begin
         if (high_clock_en_i)
            hdiv_r <= hdiv_nxt;
         if (low_clock_en_i)
            ldiv_r <= ldiv_nxt;
      end
   end

   // A tap of 2^n fires when the low n bits wrap on an enable.
   function automatic logic tap_hit(input logic [`CTPWM_DIV_W-1:0] v, input int n);
      logic [`CTPWM_DIV_W-1:0] m;
      m = `CTPWM_DIV_W'((1 << n) - 1);
      return (v & m) == m;
   endfunction : tap_hit

   // ----------------------------------------------------------------
   // External event input
   // ----------------------------------------------------------------
   logic ev_s1_r;
   logic ev_s2_r;
   logic ev_s3_r;

   // Two flops synchronise the pin, the third feeds the edge detector.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         ev_s1_r <= 1'b1;
         ev_s2_r <= 1'b1;
         ev_s3_r <= 1'b1;
      end
      else
      begin
         ev_s1_r <= event_input_pin_i;
         ev_s2_r <= ev_s1_r;
         ev_s3_r <= ev_s2_r;
      end
   end

   // ----------------------------------------------------------------
   // Tick select
   // ----------------------------------------------------------------
   logic hi_tick;
   logic lo_tick;
   logic tick_nxt;

   // Slow modes leave only the low clock taps; fast-only taps never tick.
   always_comb
   begin
      hi_tick = high_clock_en_i && !slow_mode_i;
      lo_tick = low_clock_en_i && tap_hit({8'h00, ldiv_r}, `CTPWM_TAP_LO3);
      tick_nxt = 1'b0;
      case (src_i)
         CTPWM_SRC_TAP1: tick_nxt = (prescale_select_bit_i || slow_mode_i) ? lo_tick
            : hi_tick && tap_hit(hdiv_r, `CTPWM_TAP_HI11);
         CTPWM_SRC_HI7: tick_nxt = hi_tick && tap_hit(hdiv_r, `CTPWM_TAP_HI7);
         CTPWM_SRC_HI5: tick_nxt = hi_tick && tap_hit(hdiv_r, `CTPWM_TAP_HI5);
         CTPWM_SRC_HI3: tick_nxt = hi_tick && tap_hit(hdiv_r, `CTPWM_TAP_HI3);
         CTPWM_SRC_LOW: tick_nxt = pwm_mode_i && low_clock_en_i;
         CTPWM_SRC_HI1: tick_nxt = pwm_mode_i && hi_tick
            && tap_hit(hdiv_r, `CTPWM_TAP_HI1);
         CTPWM_SRC_HI: tick_nxt = pwm_mode_i && hi_tick;
         CTPWM_SRC_EXT: tick_nxt = !ev_s2_r && ev_s3_r;
         default: tick_nxt = 1'b0;
      endcase
   end

   // Registered so the tick is a clean one-cycle pulse.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         tick_o <= 1'b0;
      else
         tick_o <= tick_nxt;
   end

   // A falling edge on the synchronised input yields one tick one cycle later.
   AST_EXT_EDGE_TICK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (src_i == CTPWM_SRC_EXT) && $fell(ev_s2_r) ##1 (src_i == CTPWM_SRC_EXT) |-> tick_o)
      else $error("falling edge on event input gave no tick");
endmodule : ctpwm_tick

// ### rtl/ctpwm_core.sv
// Cascaded 16-bit timer, event counter and PWM generator top level.
// Function
// - Timer mode: 16-bit up-counter on internal ticks.
// - Running: period match interrupts, clears, continues.
// - Period unbuffered; new value used immediately.
// - Event mode counts external falling edges.
// - PWM counts internal or external clock.
// - PWM duty match toggles flip-flop, no clear.
// - PWM overflow toggles, clears, interrupts.
// - Flip-flop starts from init bit; reset 0.
// - PWM pin is inverse of flip-flop.
// - Running duty write buffered until interrupt.
// - Stopped duty write transfers immediately.
// - Duty read returns active duty in PWM, buffer otherwise.
// - Stopped: pin holds; init change after stop.
// - Timer source taps per divider select.
// - PWM adds low, half-high, high clocks.
`timescale 1ns/1ps
`include "ctpwm_cfg.svh"
module ctpwm_core
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic high_clock_en_i,
   input wire logic low_clock_en_i,
   input wire logic slow_mode_i,
   input wire logic prescale_select_bit_i,
   input wire ctpwm_pkg::ctpwm_mode_t mode_i,
   input wire ctpwm_pkg::ctpwm_src_t src_i,
   input wire logic cascade_run_bit_i,
   input wire logic high_flipflop_init_bit_i,
   input wire logic init_load_i,
   input wire logic [7:0] wr_data_i,
   input wire logic period_reg_low_wr_i,
   input wire logic period_reg_high_wr_i,
   input wire logic duty_reg_low_wr_i,
   input wire logic duty_reg_high_wr_i,
   input wire logic event_input_pin_i,
   output logic [15:0] period_rd_o,
   output logic [15:0] duty_rd_o,
   output logic [15:0] count_o,
   output logic cascade_match_irq_o,
   output logic cascade_pwm_pin_o
);
   import ctpwm_pkg::*;

   // ----------------------------------------------------------------
   // Tick source
   // ----------------------------------------------------------------
   logic tick;
   logic pwm_mode;
   ctpwm_src_t tick_src;
   assign pwm_mode = (mode_i == CTPWM_MODE_PWM);
   // Event mode always counts pin edges, whatever source field is left set.
   assign tick_src = (mode_i == CTPWM_MODE_EVENT) ? CTPWM_SRC_EXT : src_i;

   ctpwm_tick u_tick
   (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .high_clock_en_i(high_clock_en_i),
      .low_clock_en_i(low_clock_en_i),
      .prescale_select_bit_i(prescale_select_bit_i),
      .slow_mode_i(slow_mode_i),
      .pwm_mode_i(pwm_mode),
      .src_i(tick_src),
      .event_input_pin_i(event_input_pin_i),
      .tick_o(tick)
   );

   // ----------------------------------------------------------------
   // Period register
   // ----------------------------------------------------------------
   logic [`CTPWM_HALF_W-1:0] period_lo_r;
   logic [`CTPWM_HALF_W-1:0] period_hi_r;
   logic [`CTPWM_CNT_W-1:0] period;
   assign period = {period_hi_r, period_lo_r};

   // No shadow: the compare sees a new byte on the very next cycle.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         period_lo_r <= '0;
         period_hi_r <= '0;
      end
      else
      begin
         if (period_reg_low_wr_i)
            period_lo_r <= wr_data_i;
         if (period_reg_high_wr_i)
            period_hi_r <= wr_data_i;
      end
   end

   // ----------------------------------------------------------------
   // Counter halves
   // ----------------------------------------------------------------
   logic [`CTPWM_HALF_W-1:0] cnt_lo_r;
   logic [`CTPWM_HALF_W-1:0] cnt_hi_r;
   logic [`CTPWM_CNT_W-1:0] cnt;
   logic run;
   logic adv;
   logic carry;
   logic period_hit;
   logic duty_hit;
   logic ovf;
   logic [`CTPWM_CNT_W-1:0] duty_act_r;

   assign cnt = {cnt_hi_r, cnt_lo_r};
   assign run = cascade_run_bit_i && (mode_i != CTPWM_MODE_RSVD);
   assign adv = run && tick;
   assign carry = (cnt_lo_r == 8'hff);
   assign period_hit = !pwm_mode && (cnt == period);
   assign duty_hit = pwm_mode && (cnt == duty_act_r);
   assign ovf = pwm_mode && (cnt == 16'hffff);

   // The low half carries into the high half; a match or overflow
   // clears both halves on the tick that would otherwise step past it.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         cnt_lo_r <= 8'h00;
         cnt_hi_r <= 8'h00;
      end
      else if (!cascade_run_bit_i)
      begin
         cnt_lo_r <= 8'h00;
         cnt_hi_r <= 8'h00;
      end
      else if (adv)
      begin
         if (period_hit || ovf)
         begin
            cnt_lo_r <= 8'h00;
            cnt_hi_r <= 8'h00;
         end
         else
         begin
            cnt_lo_r <= cnt_lo_r + 8'h01;
            if (carry)
               cnt_hi_r <= cnt_hi_r + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt event
   // ----------------------------------------------------------------
   logic irq_ev;
   assign irq_ev = adv && (period_hit || ovf);

   // One-cycle pulse on each match or overflow.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         cascade_match_irq_o <= 1'b0;
      else
         cascade_match_irq_o <= irq_ev;
   end

   // ----------------------------------------------------------------
   // Duty buffer
   // ----------------------------------------------------------------
   logic [`CTPWM_CNT_W-1:0] duty_buf_r;
   logic duty_pend_r;

   // Writes land in the buffer; each byte write sets its own half.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         duty_buf_r <= `CTPWM_DUTY_RST;
      else
      begin
         if (duty_reg_low_wr_i)
            duty_buf_r[7:0] <= wr_data_i;
         if (duty_reg_high_wr_i)
            duty_buf_r[15:8] <= wr_data_i;
      end
   end

   // Transfer immediately when stopped, else on the interrupt event.
   // A write in the same cycle as the event loads the old buffer, which
   // software is told to avoid.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         duty_act_r <= `CTPWM_DUTY_RST;
         duty_pend_r <= 1'b0;
      end
      else if (!cascade_run_bit_i)
      begin
         duty_pend_r <= duty_reg_high_wr_i || duty_reg_low_wr_i;
         if (duty_pend_r)
            duty_act_r <= duty_buf_r;
      end
      else if (irq_ev)
      begin
         duty_act_r <= duty_buf_r;
         duty_pend_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Output flip-flop
   // ----------------------------------------------------------------
   logic tff_r;

   // Load from the init bit only while stopped; toggle on duty match
   // and again on overflow. Holding the level while stopped keeps the pin.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         tff_r <= 1'b0;
      else if (!cascade_run_bit_i)
      begin
         if (init_load_i)
            tff_r <= high_flipflop_init_bit_i;
      end
      else if (adv && (duty_hit || ovf))
         tff_r <= ~tff_r;
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   // Every output comes straight from a flop, so reads lag the state by one cycle.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         cascade_pwm_pin_o <= 1'b1;
         period_rd_o <= '0;
         duty_rd_o <= `CTPWM_DUTY_RST;
         count_o <= `CTPWM_CNT_RST;
      end
      else
      begin
         cascade_pwm_pin_o <= ~tff_r;
         period_rd_o <= period;
         duty_rd_o <= pwm_mode ? duty_act_r : duty_buf_r;
         count_o <= cnt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_PERIOD_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      adv && period_hit |=> cnt == 16'h0000 && cascade_match_irq_o)
      else $error("period match did not clear and interrupt");

   AST_COUNT_STEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      adv && !period_hit && !ovf |=> cnt == $past(cnt) + 16'h0001)
      else $error("counter did not step by one");

   AST_HOLD_NO_TICK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cascade_run_bit_i && !tick ##1 cascade_run_bit_i |-> $stable(cnt))
      else $error("counter moved without a tick");

   AST_DUTY_TOGGLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cascade_run_bit_i && adv && duty_hit && !ovf |=> tff_r != $past(tff_r)
      && cnt != 16'h0000)
      else $error("duty match did not toggle without clearing");

   AST_OVF_WRAP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      adv && ovf |=> cnt == 16'h0000 && cascade_match_irq_o)
      else $error("overflow did not clear and interrupt");

   AST_PIN_INV: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ##1 cascade_pwm_pin_o == !$past(tff_r))
      else $error("pin is not inverse of flip-flop");

   AST_DUTY_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cascade_run_bit_i && !irq_ev |=> $stable(duty_act_r))
      else $error("active duty changed while running without event");

   AST_STOP_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !cascade_run_bit_i && duty_reg_high_wr_i ##1 !cascade_run_bit_i
      |=> duty_act_r == $past(duty_buf_r))
      else $error("stopped duty write not transferred");

   AST_STOP_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !cascade_run_bit_i && !init_load_i |=> $stable(tff_r))
      else $error("flip-flop moved while stopped");

   AST_INIT_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !cascade_run_bit_i && init_load_i |=> tff_r == $past(high_flipflop_init_bit_i))
      else $error("stopped init load did not set the flip-flop");

   AST_RUN_NO_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cascade_run_bit_i && init_load_i && !(adv && (duty_hit || ovf)) |=> $stable(tff_r))
      else $error("init load changed the flip-flop while running");

   AST_DUTY_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pwm_mode |=> duty_rd_o == $past(duty_act_r))
      else $error("duty read does not show the loaded value");
endmodule : ctpwm_core

// ### dv/ctpwm_evt_src.sv
// External pulse source that drives the event counter input pin.
`timescale 1ns/1ps
module ctpwm_evt_src
(
   input wire logic clk_i,
   input wire logic en_i,
   output logic pin_o
);
   logic [1:0] cnt_r;
   // Each level is held four system cycles, twice the minimum, so edges are never lost.
   // While disabled the pin rests high, so no stray falling edge appears between runs.
   always_ff @(negedge clk_i)
   begin
      if (!en_i)
      begin
         cnt_r <= 2'h0;
         pin_o <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 2'h1;
         if (cnt_r == 2'h3)
         begin
            pin_o <= !pin_o;
         end
      end
   end
endmodule : ctpwm_evt_src

// ### dv/testbench.sv
// Self-checking testbench for the cascaded 16-bit timer and PWM unit.
`timescale 1ns/1ps
module testbench;
   import ctpwm_pkg::*;
   typedef struct {
      ctpwm_mode_t mode;
      ctpwm_src_t src;
      logic sel;
      logic slow;
      logic [15:0] per;
      int expv;
   } ctpwm_row_t;
   logic sys_clk, rst, hi_en, lo_en, slow, sel, run, init, ld, ev_en, ev_pin;
   logic pl, ph, dl, dh, irq, pin;
   logic [1:0] lcnt;
   logic [7:0] wd;
   logic [15:0] per_rd, duty_rd, cnt;
   ctpwm_mode_t mode;
   ctpwm_src_t src;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   // Expected cycles between two interrupts; zero means no interrupt may come.
   ctpwm_row_t rows [13] = '{
      '{CTPWM_MODE_TIMER, CTPWM_SRC_HI3, 1'b0, 1'b0, 16'h0003, 32},
      '{CTPWM_MODE_TIMER, CTPWM_SRC_HI3, 1'b0, 1'b0, 16'h0100, 2056},
      '{CTPWM_MODE_TIMER, CTPWM_SRC_HI5, 1'b0, 1'b0, 16'h0001, 64},
      '{CTPWM_MODE_TIMER, CTPWM_SRC_HI7, 1'b0, 1'b0, 16'h0001, 256},
      '{CTPWM_MODE_TIMER, CTPWM_SRC_TAP1, 1'b0, 1'b0, 16'h0001, 4096},
      '{CTPWM_MODE_TIMER, CTPWM_SRC_TAP1, 1'b1, 1'b1, 16'h0001, 64},
      '{CTPWM_MODE_TIMER, CTPWM_SRC_HI3, 1'b0, 1'b1, 16'h0001, 0},
      '{CTPWM_MODE_TIMER, CTPWM_SRC_HI, 1'b0, 1'b0, 16'h0001, 0},
      '{CTPWM_MODE_TIMER, CTPWM_SRC_TAP1, 1'b1, 1'b0, 16'h0001, 64},
      '{CTPWM_MODE_TIMER, CTPWM_SRC_LOW, 1'b0, 1'b0, 16'h0001, 0},
      '{CTPWM_MODE_TIMER, CTPWM_SRC_HI1, 1'b0, 1'b0, 16'h0001, 0},
      '{CTPWM_MODE_RSVD, CTPWM_SRC_HI3, 1'b0, 1'b0, 16'h0001, 0},
      '{CTPWM_MODE_EVENT, CTPWM_SRC_EXT, 1'b0, 1'b0, 16'h0002, 24}
   };

   ctpwm_core ctpwm_core_i (.sys_clk_i(sys_clk), .rst_i(rst), .high_clock_en_i(hi_en),
      .low_clock_en_i(lo_en), .slow_mode_i(slow), .prescale_select_bit_i(sel),
      .mode_i(mode), .src_i(src), .cascade_run_bit_i(run), .high_flipflop_init_bit_i(init),
      .init_load_i(ld), .wr_data_i(wd), .period_reg_low_wr_i(pl), .period_reg_high_wr_i(ph),
      .duty_reg_low_wr_i(dl), .duty_reg_high_wr_i(dh), .event_input_pin_i(ev_pin),
      .period_rd_o(per_rd), .duty_rd_o(duty_rd), .count_o(cnt), .cascade_match_irq_o(irq),
      .cascade_pwm_pin_o(pin));
   ctpwm_evt_src ctpwm_evt_src_i (.clk_i(sys_clk), .en_i(ev_en), .pin_o(ev_pin));

   // ----------------------------------------
   // Clock, low clock enable and timeout
   // ----------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = !sys_clk;
   end
   // The low clock enable pulses every fourth cycle, so its divide-by-8 tap ticks every 32.
   always @(negedge sys_clk)
   begin
      lcnt <= lcnt + 2'h1;
      lo_en <= (lcnt == 2'h3);
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 95000)
      begin
         err_count++;
         summarize();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic summarize();
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task automatic chk(input logic [15:0] got, input logic [15:0] expv);
      n_compared++;
      if (got !== expv)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, expv);
      end
   endtask : chk

   task automatic wait_n(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wait_n

   // Low byte always goes first; a lone byte write is never issued.
   task automatic wr16(input logic duty, input logic [15:0] v);
      @(negedge sys_clk);
      wd = v[7:0];
      pl = !duty;
      dl = duty;
      @(negedge sys_clk);
      pl = 1'b0;
      dl = 1'b0;
      wd = v[15:8];
      ph = !duty;
      dh = duty;
      @(negedge sys_clk);
      ph = 1'b0;
      dh = 1'b0;
   endtask : wr16

   task automatic reset_chk();
      rst = 1'b1;
      wait_n(4);
      rst = 1'b0;
      wait_n(1);
      chk(cnt, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      chk({15'h0, pin}, 16'h0001);
      chk(duty_rd, 16'hffff);
      chk(per_rd, 16'h0000);
   endtask : reset_chk

   // Bounded wait for the interrupt, giving up after lim cycles.
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim)
      begin
         @(negedge sys_clk);
         n++;
      end
   endtask : wait_irq

   task automatic wait_pin(input logic lvl);
      int n;
      n = 0;
      while (pin !== lvl && n < 200)
      begin
         @(negedge sys_clk);
         n++;
      end
   endtask : wait_pin

   task automatic meas(input ctpwm_row_t r);
      int n;
      run = 1'b0;
      wait_n(2);
      mode = r.mode;
      src = r.src;
      sel = r.sel;
      slow = r.slow;
      init = 1'b0;
      ev_en = (r.src == CTPWM_SRC_EXT);
      wr16(1'b0, r.per);
      wait_n(1);
      chk(per_rd, r.per);
      run = 1'b1;
      wait_irq(2 * r.expv + 600);
      if (r.expv == 0)
      begin
         chk({15'h0, irq}, 16'h0000);
         return;
      end
      // The counter output lags the interrupt pulse by one cycle.
      wait_n(1);
      chk(cnt, 16'h0000);
      n = 1;
      do
      begin
         @(negedge sys_clk);
         n++;
      end while (irq !== 1'b1 && n < 2 * r.expv + 8);
      chk(n[15:0], r.expv[15:0]);
      ev_en = 1'b0;
   endtask : meas

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {slow, sel, run, init, ld, ev_en, pl, ph, dl, dh} = '0;
      rst = 1'b1;
      hi_en = 1'b1;
      lo_en = 1'b0;
      lcnt = 2'h0;
      wd = 8'h00;
      mode = CTPWM_MODE_TIMER;
      src = CTPWM_SRC_HI3;
      @(negedge sys_clk);
      reset_chk();
      foreach (rows[i])
         meas(rows[i]);
      // PWM: load init level and duty while stopped.
      run = 1'b0;
      wait_n(2);
      mode = CTPWM_MODE_PWM;
      src = CTPWM_SRC_HI;
      ld = 1'b1;
      wait_n(1);
      ld = 1'b0;
      wait_n(2);
      chk({15'h0, pin}, 16'h0001);
      wr16(1'b1, 16'h0020);
      wait_n(3);
      chk(duty_rd, 16'h0020);
      // A load of the init level while running must be ignored.
      run = 1'b1;
      init = 1'b1;
      ld = 1'b1;
      wait_n(1);
      ld = 1'b0;
      init = 1'b0;
      wait_pin(1'b0);
      chk({15'h0, (cnt >= 16'h0020 && cnt <= 16'h0024)}, 16'h0001);
      wr16(1'b1, 16'h0010);
      chk(duty_rd, 16'h0020);
      wait_irq(70000);
      wait_n(2);
      chk({15'h0, pin}, 16'h0001);
      chk(duty_rd, 16'h0010);
      wait_pin(1'b0);
      chk({15'h0, (cnt >= 16'h0010 && cnt <= 16'h0014)}, 16'h0001);
      // Stopping holds the pin; a later init load changes it.
      run = 1'b0;
      wait_n(10);
      chk({15'h0, pin}, 16'h0000);
      // The counter is stopped first, so freezing the high clock cannot glitch the pin.
      hi_en = 1'b0;
      wait_n(4);
      hi_en = 1'b1;
      chk({15'h0, pin}, 16'h0000);
      ld = 1'b1;
      wait_n(1);
      ld = 1'b0;
      wait_n(3);
      chk({15'h0, pin}, 16'h0001);
      run = 1'b1;
      wait_n(50);
      reset_chk();
      summarize();
   end
endmodule : testbench
